// ---- src/eiiu_filt_if.sv ----
// Interface between the unit and its input filter.
`timescale 1ns/1ns
interface eiiu_filt_if;
  logic [15:0] raw;
  logic        tick;
  logic [63:0] resp;
  logic [15:0] filt;
  modport top (output raw, output tick, output resp, input filt);
  modport flt (input raw, input tick, input resp, output filt);
endinterface

// ---- src/eiiu_filter.sv ----
// Input response filter for all sixteen lines.
`timescale 1ns/1ns
module eiiu_filter (
  // Clock and reset
  input wire logic   clk_sys_i,
  input wire logic   rst_i,
  // Filter link
  eiiu_filt_if.flt   fif
);
  eiiu_pkg::eiiu_filt_t s_reg;
  eiiu_pkg::eiiu_filt_t s_next;

  // A line follows its input only after the input stood changed for the chosen time.
  always_comb begin
    logic [16:0] lim;
    s_next = s_reg;
    lim    = '0;
    for (int i = 0; i < eiiu_pkg::LINES; i++) begin
      lim = eiiu_pkg::eiiu_resp_us(i < eiiu_pkg::HS_LINES, fif.resp[4*i +: 3]);
      if (fif.raw[i] == s_reg.filt[i]) begin
        s_next.cnt[i] = '0;
      end else if (fif.tick) begin
        if (s_reg.cnt[i] + 17'h1 >= lim) begin
          s_next.filt[i] = fif.raw[i];
          s_next.cnt[i]  = '0;
        end else begin
          s_next.cnt[i] = s_reg.cnt[i] + 17'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fif.filt = s_reg.filt;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_filt_on_tick: assert property ($changed(s_reg.filt) |-> $past(fif.tick))
    else $error("filtered value changed without a tick");
  a_filt_min_hs: assert property ($changed(s_reg.filt[0]) |-> $past(s_reg.cnt[0]) >= 17'h0_0009)
    else $error("high-speed line passed a pulse shorter than the minimum");
  a_filt_min_std: assert property ($changed(s_reg.filt[6]) |-> $past(s_reg.cnt[6]) >= 17'h0_0063)
    else $error("standard line passed a pulse shorter than the minimum");
endmodule

// ---- src/eiiu_pkg.sv ----
// Constants, register map and state types of the edge interrupt input unit.
package eiiu_pkg;
  localparam int LINES        = 16;
  localparam int HS_LINES     = 6;
  localparam int PRE_W        = 12;
  localparam int CLK_NS       = 20;
  localparam int TICK_NS      = 1000;
  localparam int CYC_PER_TICK = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRIO_BASE    = 5;
  localparam int TIMER_PRIO_N = 4;
  localparam logic [3:0] REG_CMD     = 4'h0;
  localparam logic [3:0] REG_SEL     = 4'h1;
  localparam logic [3:0] REG_TRIG    = 4'h2;
  localparam logic [3:0] REG_RESP_LO = 4'h3;
  localparam logic [3:0] REG_RESP_HI = 4'h4;
  localparam logic [3:0] REG_MASK    = 4'h5;
  localparam logic [3:0] REG_STAT    = 4'h6;
  localparam logic [3:0] REG_VEC     = 4'h7;
  localparam logic [3:0] REG_ERR     = 4'h8;
  localparam logic [3:0] REG_RUN     = 4'h9;
  localparam int CMD_EN_BIT    = 0;
  localparam int CMD_DIS_BIT   = 1;
  localparam int VEC_START_LSB = 0;
  localparam int VEC_CNT_LSB   = 8;
  localparam int VEC_LINE_LSB  = 16;
  localparam int VEC_SRC_LSB   = 24;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam logic [31:0] RST_TRIG = 32'h5555_5555;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [15:0] ERR_PARAM = 16'h0BB8;
  localparam logic [16:0] HS_US [0:5] = '{17'h0_000A, 17'h0_0064, 17'h0_00C8,
                                          17'h0_0190, 17'h0_0258, 17'h0_03E8};
  localparam logic [16:0] STD_US [0:5] = '{17'h0_0064, 17'h0_03E8, 17'h0_1388,
                                           17'h0_2710, 17'h0_4E20, 17'h1_1170};

  // Response time in ticks of one microsecond; codes above five take the longest time.
  function automatic logic [16:0] eiiu_resp_us(input logic hs, input logic [2:0] code);
    logic [2:0] idx;
    idx = (code > 3'h5) ? 3'h5 : code;
    return hs ? HS_US[idx] : STD_US[idx];
  endfunction

  typedef struct packed {
    logic [15:0]       filt;
    logic [15:0][16:0] cnt;
  } eiiu_filt_t;

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] filt_d;
    logic [11:0] pre;
    logic        tick;
    logic        gen_en;
    logic [15:0] sel;
    logic [15:0] mask;
    logic [15:0] pend;
    logic [15:0] run;
    logic [31:0] trig;
    logic [31:0] resp_lo;
    logic [31:0] resp_hi;
    logic [31:0] vec;
    logic [31:0] rdata;
    logic [15:0] err;
    logic        cfg_err;
    logic        irq;
    logic        req_valid;
    logic [7:0]  req_vec;
    logic [4:0]  req_prio;
    logic [3:0]  req_line;
  } eiiu_state_t;
endpackage

// ---- src/eiiu_top.sv ----
// Edge interrupt input unit: synchroniser, edge detection, pending flags and arbitration.
`timescale 1ns/1ns
module eiiu_top #(
  parameter logic [11:0] TICK_CYCLES = 12'(eiiu_pkg::CYC_PER_TICK)
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // External input lines
  input  wire logic [15:0] external_input_lines_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  // Processor request port
  output logic             irq_o,
  output logic             req_valid_o,
  output logic      [7:0]  req_vector_o,
  output logic      [4:0]  req_prio_o,
  output logic      [3:0]  req_line_o,
  input  wire logic        accept_i,
  input  wire logic        done_i,
  input  wire logic [3:0]  done_line_i,
  // Configuration status
  output logic             cfg_err_o
);
  eiiu_pkg::eiiu_state_t s_reg;
  eiiu_pkg::eiiu_state_t s_next;

  logic [15:0] rise_c;
  logic [15:0] fall_c;
  logic [15:0] qual_c;
  logic [15:0] new_ev_c;
  logic [15:0] clr_c;
  logic [15:0] range_c;
  logic [15:0] cand_c;

  eiiu_filt_if fif ();

  assign fif.raw  = s_reg.sync2;
  assign fif.tick = s_reg.tick;
  assign fif.resp = {s_reg.resp_hi, s_reg.resp_lo};

  eiiu_filter u_filter (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .fif       (fif)
  );

  always_comb begin
    logic [1:0] tc;
    logic [4:0] off;
    logic [4:0] cnt;
    logic [4:0] sl;
    logic [3:0] ln;
    s_next   = s_reg;
    tc       = '0;
    off      = '0;
    cnt      = '0;
    sl       = '0;
    ln       = '0;
    rise_c   = '0;
    fall_c   = '0;
    qual_c   = '0;
    range_c  = '0;
    cand_c   = '0;
    clr_c    = '0;

    // Two flip-flops before the filter reads the lines.
    s_next.sync1  = external_input_lines_i;
    s_next.sync2  = s_reg.sync1;
    s_next.filt_d = fif.filt;

    // Microsecond tick for the filter counters.
    if (s_reg.pre >= TICK_CYCLES - 12'h001) begin
      s_next.pre  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.pre  = s_reg.pre + 12'h001;
      s_next.tick = 1'b0;
    end

    // Register writes.
    if (reg_we_i) begin
      case (reg_addr_i)
        eiiu_pkg::REG_CMD: begin
          if (reg_wdata_i[eiiu_pkg::CMD_DIS_BIT]) begin
            s_next.gen_en = 1'b0;
          end else if (reg_wdata_i[eiiu_pkg::CMD_EN_BIT]) begin
            s_next.gen_en = 1'b1;
          end
        end
        eiiu_pkg::REG_SEL: begin
          s_next.sel = reg_wdata_i[15:0];
        end
        eiiu_pkg::REG_TRIG: begin
          s_next.trig = reg_wdata_i;
        end
        eiiu_pkg::REG_RESP_LO: begin
          s_next.resp_lo = reg_wdata_i;
        end
        eiiu_pkg::REG_RESP_HI: begin
          s_next.resp_hi = reg_wdata_i;
        end
        eiiu_pkg::REG_MASK: begin
          s_next.mask = reg_wdata_i[15:0];
        end
        eiiu_pkg::REG_STAT: begin
          clr_c = reg_wdata_i[15:0];
        end
        eiiu_pkg::REG_VEC: begin
          s_next.vec = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Register reads; data stand only in the cycle after the strobe.
    s_next.rdata = '0;
    if (reg_re_i) begin
      case (reg_addr_i)
        eiiu_pkg::REG_CMD:     s_next.rdata = {31'h0, s_reg.gen_en};
        eiiu_pkg::REG_SEL:     s_next.rdata = {16'h0, s_reg.sel};
        eiiu_pkg::REG_TRIG:    s_next.rdata = s_reg.trig;
        eiiu_pkg::REG_RESP_LO: s_next.rdata = s_reg.resp_lo;
        eiiu_pkg::REG_RESP_HI: s_next.rdata = s_reg.resp_hi;
        eiiu_pkg::REG_MASK:    s_next.rdata = {16'h0, s_reg.mask};
        eiiu_pkg::REG_STAT:    s_next.rdata = {16'h0, s_reg.pend};
        eiiu_pkg::REG_VEC:     s_next.rdata = s_reg.vec;
        eiiu_pkg::REG_ERR:     s_next.rdata = {16'h0, s_reg.err};
        eiiu_pkg::REG_RUN:     s_next.rdata = {16'h0, s_reg.run};
        default:               s_next.rdata = '0;
      endcase
    end

    // Edges of the filtered lines against their value one cycle earlier.
    rise_c = fif.filt & ~s_reg.filt_d;
    fall_c = ~fif.filt & s_reg.filt_d;
    for (int i = 0; i < eiiu_pkg::LINES; i++) begin
      tc = s_reg.trig[2*i +: 2];
      qual_c[i] = (((tc == eiiu_pkg::TRIG_RISE) || (tc == eiiu_pkg::TRIG_BOTH)) && rise_c[i]) ||
                  (((tc == eiiu_pkg::TRIG_FALL) || (tc == eiiu_pkg::TRIG_BOTH)) && fall_c[i]);
    end
    new_ev_c = s_reg.sel & qual_c & ~s_reg.run;

    // A routine that ends frees its line again.
    if (done_i) begin
      s_next.run[done_line_i] = 1'b0;
    end

    // Accepting the shown request clears its pending flag and marks the routine running.
    if (accept_i && s_reg.req_valid) begin
      clr_c[s_reg.req_line]      = 1'b1;
      s_next.run[s_reg.req_line] = 1'b1;
    end

    // One pending flag per line; an edge in the cycle of a clear wins over it.
    s_next.pend = (s_reg.pend & ~clr_c) | new_ev_c;

    // Lines covered by the relocated vector range.
    cnt = s_next.vec[eiiu_pkg::VEC_CNT_LSB +: 5];
    sl  = {1'b0, s_next.vec[eiiu_pkg::VEC_LINE_LSB +: 4]};
    for (int i = 0; i < eiiu_pkg::LINES; i++) begin
      off        = 5'(i) - sl;
      range_c[i] = (cnt != 5'h00) && (5'(i) >= sl) && (off < cnt);
    end

    // A relocated range with no selected line is a configuration error.
    if ((cnt != 5'h00) && ((s_next.sel & range_c) == 16'h0000)) begin
      s_next.err     = eiiu_pkg::ERR_PARAM;
      s_next.cfg_err = 1'b1;
    end else begin
      s_next.err     = '0;
      s_next.cfg_err = 1'b0;
    end

    s_next.irq = s_next.gen_en & (|(s_next.pend & s_next.mask & s_next.sel));

    // The lowest line number has the highest priority.
    cand_c = s_next.pend & s_next.mask & s_next.sel & ~s_next.run & {16{s_next.gen_en}};
    for (int i = eiiu_pkg::LINES - 1; i >= 0; i--) begin
      if (cand_c[i]) begin
        ln = 4'(i);
      end
    end
    s_next.req_valid = cand_c != 16'h0000;
    s_next.req_line  = ln;
    s_next.req_prio  = 5'(eiiu_pkg::PRIO_BASE) + {1'b0, ln};
    if (range_c[ln]) begin
      s_next.req_vec = s_next.vec[eiiu_pkg::VEC_START_LSB +: 8] + {4'h0, ln - sl[3:0]};
    end else begin
      s_next.req_vec = {4'h0, ln};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.trig <= eiiu_pkg::RST_TRIG;
      s_reg.mask <= eiiu_pkg::RST_MASK;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o  = s_reg.rdata;
  assign irq_o        = s_reg.irq;
  assign req_valid_o  = s_reg.req_valid;
  assign req_vector_o = s_reg.req_vec;
  assign req_prio_o   = s_reg.req_prio;
  assign req_line_o   = s_reg.req_line;
  assign cfg_err_o    = s_reg.cfg_err;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_edge_sets_pend: assert property (new_ev_c != 16'h0000 |=> (s_reg.pend & $past(new_ev_c)) == $past(new_ev_c))
    else $error("qualifying edge did not set its pending flag");

  a_default_vector: assert property (
    req_valid_o && (s_reg.vec[eiiu_pkg::VEC_CNT_LSB +: 5] == 5'h00) |-> req_vector_o == {4'h0, req_line_o})
    else $error("default vector differs from line number");

  a_prio_level: assert property (req_valid_o |-> req_prio_o == 5'(eiiu_pkg::PRIO_BASE) + {1'b0, req_line_o})
    else $error("priority level does not match line");

  a_prio_not_timer: assert property (req_valid_o |-> req_prio_o > 5'(eiiu_pkg::TIMER_PRIO_N))
    else $error("input line used a timer priority level");

  a_cfg_err_code: assert property (
    reg_we_i && (reg_addr_i == eiiu_pkg::REG_VEC) && (reg_wdata_i[eiiu_pkg::VEC_CNT_LSB +: 5] != 5'h00) &&
    (s_reg.sel == 16'h0000) |=> cfg_err_o && (s_reg.err == eiiu_pkg::ERR_PARAM))
    else $error("empty relocated range did not report the error");

  a_single_pend: assert property (
    s_reg.pend[0] && !clr_c[0] && new_ev_c[0] |=> s_reg.pend[0] && !req_valid_o || req_line_o != 4'h0 ||
    !s_reg.run[0])
    else $error("second edge produced a second request");

  a_accept_clears: assert property (
    accept_i && req_valid_o && !new_ev_c[req_line_o] |=>
    s_reg.run[$past(req_line_o)] && !s_reg.pend[$past(req_line_o)])
    else $error("accepted request was not cleared");

  a_no_req_running: assert property (req_valid_o |-> !s_reg.run[req_line_o])
    else $error("request shown for a running line");

  a_disable_gates: assert property (
    reg_we_i && (reg_addr_i == eiiu_pkg::REG_CMD) && reg_wdata_i[eiiu_pkg::CMD_DIS_BIT] |=> !req_valid_o && !irq_o)
    else $error("request shown after disable command");

  a_mask_gates: assert property (req_valid_o |-> s_reg.mask[req_line_o] && s_reg.sel[req_line_o])
    else $error("request shown for a masked or unselected line");

  a_read_window: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  c_accept: cover property (req_valid_o ##1 accept_i && req_valid_o);
  c_both_edges: cover property (s_reg.trig[1:0] == eiiu_pkg::TRIG_BOTH && fall_c[0] && s_reg.pend[0]);
  c_cfg_err: cover property ($rose(cfg_err_o));
  c_relocated: cover property (req_valid_o && req_vector_o != {4'h0, req_line_o});
endmodule

// ---- verification/eiiu_src_model.sv ----
// Behavioural model of the switches and sensors that drive the input lines.
`timescale 1ns/1ns
module eiiu_src_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Lines towards the unit
  output logic      [15:0] lines_o
);
  initial lines_o = 16'h0000;

  task automatic level(input int ln, input logic v);
    @(posedge clk_sys_i);
    lines_o[ln] <= v;
  endtask

  // The rest after a pulse outlasts the slowest filter time in use, so no edge is lost.
  task automatic pulse(input int ln, input int w);
    level(ln, 1'b1);
    repeat (w) @(posedge clk_sys_i);
    lines_o[ln] <= 1'b0;
    repeat (150) @(posedge clk_sys_i);
  endtask
endmodule

// ---- verification/test_edge_interrupt_input_unit.sv ----
// Self-checking testbench of the edge interrupt input unit.
`timescale 1ns/1ns
module test_edge_interrupt_input_unit;
  typedef struct {string nm; logic [31:0] v;} eiiu_note_t;
  logic        clk_sys_i, rst_i, reg_we_i, reg_re_i, accept_i, done_i, smp, rd_q;
  logic [3:0]  reg_addr_i, done_line_i, req_line_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, r;
  logic [15:0] lines;
  logic        irq_o, req_valid_o, cfg_err_o;
  logic [7:0]  req_vector_o;
  logic [4:0]  req_prio_o;
  eiiu_note_t  notes[$];
  int          failures, cmp_count;

  eiiu_top #(.TICK_CYCLES(12'h001)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .external_input_lines_i(lines),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .req_valid_o(req_valid_o), .req_vector_o(req_vector_o),
    .req_prio_o(req_prio_o), .req_line_o(req_line_o), .accept_i(accept_i), .done_i(done_i),
    .done_line_i(done_line_i), .cfg_err_o(cfg_err_o));
  eiiu_src_model src (.clk_sys_i(clk_sys_i), .lines_o(lines));

  task automatic print_verdict();
    $display("counts comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic compare(input logic [31:0] seen);
    eiiu_note_t n;
    if (notes.size() == 0) begin
      failures++;
      $display("mismatch unexpected result expected none seen %h", seen);
    end else begin
      n = notes.pop_front();
      cmp_count++;
      if (seen !== n.v) begin
        failures++;
        $display("mismatch %s expected %h seen %h", n.nm, n.v, seen);
      end
    end
  endtask

  // Read data, accepted requests and sampled flags each appear in a cycle the monitor can tell apart.
  always @(posedge clk_sys_i) begin
    rd_q <= reg_re_i;
    if (rd_q)
      compare(reg_rdata_o);
    else if (accept_i && req_valid_o === 1'b1)
      compare({15'h0000, req_vector_o, req_prio_o, req_line_o});
    else if (smp)
      compare({29'h0000_0000, cfg_err_o, irq_o, req_valid_o});
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    notes.push_back('{nm, e});
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
  endtask

  task automatic flags(input logic [2:0] e);
    @(posedge clk_sys_i);
    smp <= 1'b1;
    notes.push_back('{"flags", {29'h0000_0000, e}});
    @(posedge clk_sys_i);
    smp <= 1'b0;
  endtask

  task automatic acc(input logic [7:0] vec, input logic [3:0] ln);
    int i;
    i = 0;
    while (req_valid_o !== 1'b1 && i < 400) begin
      @(negedge clk_sys_i);
      i++;
    end
    if (i == 400) begin
      failures++;
      $display("mismatch req_valid expected 1 seen 0");
      print_verdict();
    end
    @(posedge clk_sys_i);
    accept_i <= 1'b1;
    notes.push_back('{"request", {15'h0000, vec, 5'(eiiu_pkg::PRIO_BASE + int'(ln)), ln}});
    @(posedge clk_sys_i);
    accept_i <= 1'b0;
  endtask

  task automatic fin(input logic [3:0] ln);
    @(posedge clk_sys_i);
    done_i      <= 1'b1;
    done_line_i <= ln;
    @(posedge clk_sys_i);
    done_i <= 1'b0;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    {rst_i, reg_we_i, reg_re_i, accept_i, done_i, smp} = 6'h20;
    {reg_addr_i, done_line_i, reg_wdata_i} = 40'h00_0000_0000;
    failures  = 0;
    cmp_count = 0;
    r = $urandom(99732);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd("cmd", eiiu_pkg::REG_CMD, 32'h0000_0000);
    rd("sel", eiiu_pkg::REG_SEL, 32'h0000_0000);
    rd("trig", eiiu_pkg::REG_TRIG, eiiu_pkg::RST_TRIG);
    rd("mask", eiiu_pkg::REG_MASK, {16'h0000, eiiu_pkg::RST_MASK});
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    rd("err", eiiu_pkg::REG_ERR, 32'h0000_0000);
    rd("unmapped", 4'hF, 32'h0000_0000);
    r = $urandom;
    wr(eiiu_pkg::REG_SEL, r);
    rd("sel", eiiu_pkg::REG_SEL, {16'h0000, r[15:0]});
    $display("test registers done");
    wr(eiiu_pkg::REG_SEL, 32'h0000_FFFF);
    wr(eiiu_pkg::REG_CMD, 32'h0000_0001);
    for (int m = 1; m < 4; m++) begin
      wr(eiiu_pkg::REG_TRIG, 32'(m) << (2 * m));
      src.pulse(m, 20 + int'($urandom % 8));
      acc(8'(m), 4'(m));
      fin(4'(m));
      rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    end
    src.level(3, 1'b1);
    acc(8'h03, 4'h3);
    src.level(3, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    fin(4'h3);
    flags(3'b000);
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    $display("test trigger modes done");
    wr(eiiu_pkg::REG_TRIG, 32'h0000_0100);
    wr(eiiu_pkg::REG_CMD, 32'h0000_0002);
    src.level(4, 1'b1);
    repeat (30) @(posedge clk_sys_i);
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0010);
    flags(3'b000);
    wr(eiiu_pkg::REG_MASK, 32'h0000_FFEF);
    wr(eiiu_pkg::REG_CMD, 32'h0000_0001);
    flags(3'b000);
    wr(eiiu_pkg::REG_MASK, 32'h0000_FFFF);
    flags(3'b011);
    acc(8'h04, 4'h4);
    fin(4'h4);
    src.level(4, 1'b0);
    $display("test enable and mask done");
    wr(eiiu_pkg::REG_TRIG, 32'h0000_0004);
    wr(eiiu_pkg::REG_VEC, 32'h0000_0250);
    src.pulse(1, 20);
    acc(8'h51, 4'h1);
    fin(4'h1);
    wr(eiiu_pkg::REG_SEL, 32'h0000_000C);
    wr(eiiu_pkg::REG_VEC, 32'h0000_0250);
    rd("err", eiiu_pkg::REG_ERR, {16'h0000, eiiu_pkg::ERR_PARAM});
    flags(3'b100);
    wr(eiiu_pkg::REG_SEL, 32'h0000_FFFF);
    wr(eiiu_pkg::REG_VEC, 32'h0000_0000);
    rd("err", eiiu_pkg::REG_ERR, 32'h0000_0000);
    $display("test relocation done");
    wr(eiiu_pkg::REG_TRIG, 32'h0000_1001);
    src.pulse(0, 6);
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    src.pulse(6, 60);
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    src.pulse(6, 110 + int'($urandom % 8));
    acc(8'h06, 4'h6);
    fin(4'h6);
    wr(eiiu_pkg::REG_RESP_LO, 32'h0000_0001);
    src.pulse(0, 60);
    rd("stat", eiiu_pkg::REG_STAT, 32'h0000_0000);
    src.pulse(0, 120);
    acc(8'h00, 4'h0);
    fin(4'h0);
    repeat (4) @(posedge clk_sys_i);
    $display("test filters done");
    if (notes.size() != 0) begin
      failures++;
      $display("mismatch notes expected 0 seen %0d", notes.size());
    end
    print_verdict();
  end
endmodule
